// File: phy_basic_ctrl_status_regs.sv
// Basic control and status registers of a PHY behind a serial management slave
//
// How it works
// - Control at index 0, status at 1
// - Bit 15 restores defaults, then self-clears
// - Loopback: no line transmit, data looped back
// - Bit 13 forces speed, resets to one
// - Autoneg enable overrides forced speed, duplex
// - Autoneg enable reset value from strap
// - Bit 11 general power down, resets zero
// - Bit 9 restarts autoneg, self-clears
// - Bit 8 forces duplex, resets to one
// - Collision test asserts collision while transmitting
// - Status 15..9 fixed ability bits
// - Status bit 8 reads zero
// - Status bit 7 reads zero
// - Preamble always required, bit 6 zero
// - Status bit 5 shows autoneg complete
// - Status bit 4 latched-high remote fault
// - Status bit 3 reads one
// - Status bit 2 latched-low link status
// - Status bit 1 latched-high jabber
// - Status bit 0 reads one
// - Reached only by serial management frames
// - Loopback powers transmitters down, collision quiet unless collision test is on
`timescale 1ns/10ps
module phy_basic_ctrl_status_regs (
    input  wire logic                      mclk_in,
    input  wire logic                      rst_in,
    // Management pins (clock and data from the master)
    input  wire logic                      mdc_in,
    input  wire logic                      mdio_in,
    output logic                           mdio_out,
    output logic                           mdio_oe_out,
    input  wire logic [4:0]                phy_addr_in,
    // Strap level from the hardware config register
    input  wire logic                      aneg_disable_in,
    // PHY core conditions and autoneg result
    input  wire phy_regs_pkg::phy_cond_s   cond_in,
    input  wire phy_regs_pkg::an_result_s  an_result_in,
    input  wire logic                      tx_en_in,
    input  wire logic                      line_col_in,
    // Control outputs
    output phy_regs_pkg::ctrl_s            ctrl_out,
    output logic                           speed_100_out,
    output logic                           full_duplex_out,
    output logic                           line_tx_enable_out,
    output logic                           collision_out,
    output logic                           soft_reset_out,
    output logic                           autoneg_restart_out
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [6:0] pins_sync;
    logic       mdc_s;
    logic       mdio_s;
    logic [4:0] addr_s;

    pin_sync #(
        .W       (7)
    ) u_pin_sync (
        .mclk_in (mclk_in),
        .rst_in  (rst_in),
        .d_in    ({phy_addr_in, mdio_in, mdc_in}),
        .q_out   (pins_sync)
    );

    assign mdc_s  = pins_sync[0];
    assign mdio_s = pins_sync[1];
    assign addr_s = pins_sync[6:2];

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        phy_regs_pkg::mgmt_state_e st;
        logic                      mdc_q;
        logic [5:0]                cnt;
        logic [1:0]                op;
        logic [9:0]                addr;
        logic [15:0]               sh;
        logic                      mdio_o;
        logic                      mdio_oe;
        logic                      init_done;
        phy_regs_pkg::ctrl_s       ctrl;
        logic                      lh_remote_fault;
        logic                      ll_link;
        logic                      lh_jabber;
        logic                      soft_reset;
        logic                      an_restart;
        logic                      speed_100;
        logic                      full_duplex;
        logic                      line_tx_en;
        logic                      col;
    } state_s;

    state_s state_r;
    state_s state_nxt;

    // ------------------------------------------------------------------
    // Read values
    // ------------------------------------------------------------------
    logic [15:0] ctrl_rd;
    logic [15:0] stat_rd;

    // Self-clearing and reserved bits read zero
    always_comb begin
        ctrl_rd                                   = 16'h0000;
        ctrl_rd[phy_regs_pkg::CTRL_LOOP_POS]      = state_r.ctrl.internal_loop_enable;
        ctrl_rd[phy_regs_pkg::CTRL_SPEED_POS]     = state_r.ctrl.forced_speed_select;
        ctrl_rd[phy_regs_pkg::CTRL_ANEG_POS]      = state_r.ctrl.autoneg_enable;
        ctrl_rd[phy_regs_pkg::CTRL_PDN_POS]       = state_r.ctrl.general_power_down;
        ctrl_rd[phy_regs_pkg::CTRL_DUPLEX_POS]    = state_r.ctrl.forced_duplex_select;
        ctrl_rd[phy_regs_pkg::CTRL_COLTEST_POS]   = state_r.ctrl.collision_test_enable;
    end

    // Fixed abilities plus live and latched conditions
    always_comb begin
        stat_rd = phy_regs_pkg::STAT_FIXED;
        stat_rd[phy_regs_pkg::STAT_AN_DONE_POS] = cond_in.an_complete;
        stat_rd[phy_regs_pkg::STAT_RFAULT_POS]  = state_r.lh_remote_fault;
        stat_rd[phy_regs_pkg::STAT_LINK_POS]    = state_r.ll_link;
        stat_rd[phy_regs_pkg::STAT_JABBER_POS]  = state_r.lh_jabber;
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    logic        mdc_rise;
    logic        addr_hit;
    logic        stat_read;
    logic [15:0] wr_word;
    logic [4:0]  reg_idx;

    assign mdc_rise = mdc_s & ~state_r.mdc_q;
    assign reg_idx  = state_r.addr[4:0];
    assign addr_hit = (state_r.addr[9:5] == addr_s);
    assign wr_word  = {state_r.sh[14:0], mdio_s};

    // Status read is flagged when the read word is snapshotted
    always_comb begin
        stat_read = 1'b0;
        if (mdc_rise && state_r.st == phy_regs_pkg::MS_ADDR
            && state_r.cnt == phy_regs_pkg::ADDR_BITS - 6'd1
            && state_r.op == phy_regs_pkg::OP_READ
            && state_r.addr[8:4] == addr_s
            && {state_r.addr[3:0], mdio_s} == phy_regs_pkg::BASIC_STATUS_IDX) begin
            stat_read = 1'b1;
        end
    end

    always_comb begin
        state_nxt            = state_r;
        state_nxt.mdc_q      = mdc_s;
        state_nxt.soft_reset = 1'b0;
        state_nxt.an_restart = 1'b0;

        // Latched bits: a read reloads the current condition, so an
        // event in the read cycle is never lost
        if (stat_read) begin
            state_nxt.lh_remote_fault = cond_in.remote_fault;
            state_nxt.ll_link         = cond_in.link_up;
            state_nxt.lh_jabber       = cond_in.jabber;
        end else begin
            state_nxt.lh_remote_fault = state_r.lh_remote_fault | cond_in.remote_fault;
            state_nxt.ll_link         = state_r.ll_link & cond_in.link_up;
            state_nxt.lh_jabber       = state_r.lh_jabber | cond_in.jabber;
        end

        // Strap captured on the first edge after reset release
        if (!state_r.init_done) begin
            state_nxt.init_done           = 1'b1;
            state_nxt.ctrl.autoneg_enable = ~aneg_disable_in;
        end

        // Frame engine, advanced on rising MDC only
        if (mdc_rise) begin
            unique case (state_r.st)
                phy_regs_pkg::MS_PREAMBLE: begin
                    // Count ones; a zero after a full preamble is start bit one
                    if (mdio_s) begin
                        if (state_r.cnt < phy_regs_pkg::PREAMBLE_BITS) begin
                            state_nxt.cnt = state_r.cnt + 6'd1;
                        end
                    end else if (state_r.cnt == phy_regs_pkg::PREAMBLE_BITS) begin
                        state_nxt.st = phy_regs_pkg::MS_START;
                    end else begin
                        state_nxt.cnt = 6'd0;
                    end
                end
                phy_regs_pkg::MS_START: begin
                    state_nxt.cnt = 6'd0;
                    state_nxt.st  = mdio_s ? phy_regs_pkg::MS_OPCODE
                                           : phy_regs_pkg::MS_PREAMBLE;
                end
                phy_regs_pkg::MS_OPCODE: begin
                    state_nxt.op = {state_r.op[0], mdio_s};
                    if (state_r.cnt == 6'd1) begin
                        state_nxt.cnt = 6'd0;
                        state_nxt.st  = phy_regs_pkg::MS_ADDR;
                    end else begin
                        state_nxt.cnt = state_r.cnt + 6'd1;
                    end
                end
                phy_regs_pkg::MS_ADDR: begin
                    // PHY address then register index, MSB first
                    state_nxt.addr = {state_r.addr[8:0], mdio_s};
                    if (state_r.cnt == phy_regs_pkg::ADDR_BITS - 6'd1) begin
                        state_nxt.cnt = 6'd0;
                        state_nxt.st  = phy_regs_pkg::MS_TURN;
                        if (stat_read) begin
                            state_nxt.sh = stat_rd;
                        end else begin
                            state_nxt.sh = ctrl_rd;
                        end
                    end else begin
                        state_nxt.cnt = state_r.cnt + 6'd1;
                    end
                end
                phy_regs_pkg::MS_TURN: begin
                    // First turnaround bit: stay released in both directions
                    state_nxt.cnt = 6'd0;
                    if (!addr_hit) begin
                        state_nxt.st = phy_regs_pkg::MS_PREAMBLE;
                    end else if (state_r.op == phy_regs_pkg::OP_READ
                                 && reg_idx <= phy_regs_pkg::BASIC_STATUS_IDX) begin
                        state_nxt.mdio_o  = 1'b0;
                        state_nxt.mdio_oe = 1'b1;
                        state_nxt.st      = phy_regs_pkg::MS_TURN_DRIVE;
                    end else if (state_r.op == phy_regs_pkg::OP_WRITE) begin
                        state_nxt.st = phy_regs_pkg::MS_WDATA;
                    end else begin
                        state_nxt.st = phy_regs_pkg::MS_PREAMBLE;
                    end
                end
                phy_regs_pkg::MS_TURN_DRIVE: begin
                    // Zero of the turnaround done; present the MSB
                    state_nxt.mdio_o = state_r.sh[15];
                    state_nxt.sh     = {state_r.sh[14:0], 1'b0};
                    state_nxt.st     = phy_regs_pkg::MS_RDATA;
                end
                phy_regs_pkg::MS_RDATA: begin
                    if (state_r.cnt == phy_regs_pkg::DATA_LAST) begin
                        state_nxt.mdio_oe = 1'b0;
                        state_nxt.mdio_o  = 1'b0;
                        state_nxt.cnt     = 6'd0;
                        state_nxt.st      = phy_regs_pkg::MS_PREAMBLE;
                    end else begin
                        state_nxt.mdio_o = state_r.sh[15];
                        state_nxt.sh     = {state_r.sh[14:0], 1'b0};
                        state_nxt.cnt    = state_r.cnt + 6'd1;
                    end
                end
                phy_regs_pkg::MS_WDATA: begin
                    // Write lands on the last data bit; second turnaround
                    // bit was skipped in MS_TURN and is the first shifted
                    state_nxt.sh = wr_word;
                    if (state_r.cnt == phy_regs_pkg::DATA_LAST + 6'd1) begin
                        state_nxt.cnt = 6'd0;
                        state_nxt.st  = phy_regs_pkg::MS_PREAMBLE;
                        if (reg_idx == phy_regs_pkg::BASIC_CONTROL_IDX) begin
                            if (wr_word[phy_regs_pkg::CTRL_SOFT_RESET_POS]) begin
                                // Defaults back, strap re-read next cycle
                                state_nxt.ctrl.internal_loop_enable  = phy_regs_pkg::CTRL_LOOP_RST;
                                state_nxt.ctrl.forced_speed_select   = phy_regs_pkg::CTRL_SPEED_RST;
                                state_nxt.ctrl.general_power_down    = phy_regs_pkg::CTRL_PDN_RST;
                                state_nxt.ctrl.forced_duplex_select  = phy_regs_pkg::CTRL_DUPLEX_RST;
                                state_nxt.ctrl.collision_test_enable = phy_regs_pkg::CTRL_COLTEST_RST;
                                state_nxt.init_done                  = 1'b0;
                                state_nxt.lh_remote_fault            = 1'b0;
                                state_nxt.ll_link                    = 1'b0;
                                state_nxt.lh_jabber                  = 1'b0;
                                state_nxt.soft_reset                 = 1'b1;
                            end else begin
                                // Reserved positions are simply not stored
                                state_nxt.ctrl.internal_loop_enable  =
                                    wr_word[phy_regs_pkg::CTRL_LOOP_POS];
                                state_nxt.ctrl.forced_speed_select   =
                                    wr_word[phy_regs_pkg::CTRL_SPEED_POS];
                                state_nxt.ctrl.autoneg_enable        =
                                    wr_word[phy_regs_pkg::CTRL_ANEG_POS];
                                state_nxt.ctrl.general_power_down    =
                                    wr_word[phy_regs_pkg::CTRL_PDN_POS];
                                state_nxt.ctrl.forced_duplex_select  =
                                    wr_word[phy_regs_pkg::CTRL_DUPLEX_POS];
                                state_nxt.ctrl.collision_test_enable =
                                    wr_word[phy_regs_pkg::CTRL_COLTEST_POS];
                                state_nxt.an_restart                 =
                                    wr_word[phy_regs_pkg::CTRL_AN_RESTART_POS];
                            end
                        end
                    end else begin
                        state_nxt.cnt = state_r.cnt + 6'd1;
                    end
                end
            endcase
        end

        // Effective speed and duplex: negotiated result wins when enabled
        if (state_r.ctrl.autoneg_enable) begin
            state_nxt.speed_100   = an_result_in.speed_100;
            state_nxt.full_duplex = an_result_in.full_duplex;
        end else begin
            state_nxt.speed_100   = state_r.ctrl.forced_speed_select;
            state_nxt.full_duplex = state_r.ctrl.forced_duplex_select;
        end

        // Transmitters off in loopback or power down, whatever tx_en says
        state_nxt.line_tx_en = tx_en_in & ~state_r.ctrl.internal_loop_enable
                               & ~state_r.ctrl.general_power_down;

        // Collision: test mode follows transmit, even in loopback; otherwise loopback keeps it quiet
        if (state_r.ctrl.collision_test_enable) begin
            state_nxt.col = tx_en_in;
        end else if (state_r.ctrl.internal_loop_enable) begin
            state_nxt.col = 1'b0;
        end else begin
            state_nxt.col = line_col_in;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Async reset to constants only; strap is caught after release
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r                            <= '0;
            state_r.st                         <= phy_regs_pkg::MS_PREAMBLE;
            state_r.ctrl.forced_speed_select   <= phy_regs_pkg::CTRL_SPEED_RST;
            state_r.ctrl.forced_duplex_select  <= phy_regs_pkg::CTRL_DUPLEX_RST;
            state_r.speed_100                  <= phy_regs_pkg::CTRL_SPEED_RST;
            state_r.full_duplex                <= phy_regs_pkg::CTRL_DUPLEX_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from state flops
    // ------------------------------------------------------------------
    assign mdio_out            = state_r.mdio_o;
    assign mdio_oe_out         = state_r.mdio_oe;
    assign ctrl_out            = state_r.ctrl;
    assign speed_100_out       = state_r.speed_100;
    assign full_duplex_out     = state_r.full_duplex;
    assign line_tx_enable_out  = state_r.line_tx_en;
    assign collision_out       = state_r.col;
    assign soft_reset_out      = state_r.soft_reset;
    assign autoneg_restart_out = state_r.an_restart;

endmodule : phy_basic_ctrl_status_regs

// File: phy_regs_pkg.sv
// Package: register map, field positions, reset values and types of the basic PHY registers
package phy_regs_pkg;

    // ------------------------------------------------------------------
    // Register indices on the serial management bus
    // ------------------------------------------------------------------
    localparam logic [4:0]  BASIC_CONTROL_IDX   = 5'h00;
    localparam logic [4:0]  BASIC_STATUS_IDX    = 5'h01;
    localparam int          REG_WIDTH           = 16;

    // ------------------------------------------------------------------
    // Control register field positions
    // ------------------------------------------------------------------
    localparam int          CTRL_SOFT_RESET_POS = 15;
    localparam int          CTRL_LOOP_POS       = 14;
    localparam int          CTRL_SPEED_POS      = 13;
    localparam int          CTRL_ANEG_POS       = 12;
    localparam int          CTRL_PDN_POS        = 11;
    localparam int          CTRL_AN_RESTART_POS = 9;
    localparam int          CTRL_DUPLEX_POS     = 8;
    localparam int          CTRL_COLTEST_POS    = 7;

    // Control reset values (autoneg enable comes from the strap)
    localparam logic        CTRL_LOOP_RST       = 1'b0;
    localparam logic        CTRL_SPEED_RST      = 1'b1;
    localparam logic        CTRL_PDN_RST        = 1'b0;
    localparam logic        CTRL_DUPLEX_RST     = 1'b1;
    localparam logic        CTRL_COLTEST_RST    = 1'b0;

    // ------------------------------------------------------------------
    // Status register: fixed ability bits and live field positions
    // ------------------------------------------------------------------
    localparam logic [15:0] STAT_FIXED          = 16'h7809;
    localparam int          STAT_AN_DONE_POS    = 5;
    localparam int          STAT_RFAULT_POS     = 4;
    localparam int          STAT_LINK_POS       = 2;
    localparam int          STAT_JABBER_POS     = 1;

    // ------------------------------------------------------------------
    // Management frame constants
    // ------------------------------------------------------------------
    localparam logic [5:0]  PREAMBLE_BITS       = 6'd32;
    localparam logic [5:0]  ADDR_BITS           = 6'd10;
    localparam logic [5:0]  DATA_LAST           = 6'd15;
    localparam logic [1:0]  OP_WRITE            = 2'b01;
    localparam logic [1:0]  OP_READ             = 2'b10;

    // Frame engine states
    typedef enum logic [2:0] {
        MS_PREAMBLE,
        MS_START,
        MS_OPCODE,
        MS_ADDR,
        MS_TURN,
        MS_TURN_DRIVE,
        MS_RDATA,
        MS_WDATA
    } mgmt_state_e;

    // Writable control fields
    typedef struct packed {
        logic internal_loop_enable;
        logic forced_speed_select;
        logic autoneg_enable;
        logic general_power_down;
        logic forced_duplex_select;
        logic collision_test_enable;
    } ctrl_s;

    // Live conditions from the PHY core
    typedef struct packed {
        logic an_complete;
        logic remote_fault;
        logic link_up;
        logic jabber;
    } phy_cond_s;

    // Negotiated result from the autoneg engine
    typedef struct packed {
        logic speed_100;
        logic full_duplex;
    } an_result_s;

endpackage : phy_regs_pkg

// File: pin_sync.sv
// Two-stage synchroniser for pins that arrive from outside the clock domain
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk_in,
    input  wire logic         rst_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_s;

    sync_s sync_r;
    sync_s sync_nxt;

    // Each bit gets its own pair of stages
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_comb begin
            sync_nxt.meta[i]   = d_in[i];
            sync_nxt.stable[i] = sync_r.meta[i];
        end
    end

    // First stage is read only by the second
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            sync_r <= '0;
        end else begin
            sync_r <= sync_nxt;
        end
    end

    assign q_out = sync_r.stable;

endmodule : pin_sync

// File: phy_regs_props.sv
// Port checks of the PHY control and status block
`timescale 1ns/10ps
module phy_regs_props (
    input wire logic mclk_in, rst_in, mdio_out, mdio_oe_out, tx_en_in, line_col_in,
    input wire phy_regs_pkg::an_result_s an_result_in,
    input wire phy_regs_pkg::ctrl_s      ctrl_out,
    input wire logic speed_100_out, full_duplex_out, line_tx_enable_out, collision_out,
    input wire logic soft_reset_out, autoneg_restart_out
);
    wire phy_regs_pkg::ctrl_s c = ctrl_out;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    // Outputs lag their causes by one cycle
    chk_tx_gate: assert property (
        line_tx_enable_out == $past(tx_en_in && !c.internal_loop_enable
            && !c.general_power_down)) else $error("line transmit gate wrong");
    chk_col_mode: assert property (
        collision_out == $past(c.collision_test_enable ? tx_en_in
            : (!c.internal_loop_enable && line_col_in))) else $error("collision wrong");
    chk_speed_sel: assert property (
        speed_100_out == $past(c.autoneg_enable ? an_result_in.speed_100
            : c.forced_speed_select)) else $error("speed wrong");
    chk_duplex_sel: assert property (
        full_duplex_out == $past(c.autoneg_enable ? an_result_in.full_duplex
            : c.forced_duplex_select)) else $error("duplex wrong");
    chk_srst_pulse: assert property (
        soft_reset_out |=> !soft_reset_out && c.forced_speed_select && !c.general_power_down
            && !c.internal_loop_enable) else $error("soft reset wrong");
    chk_restart_pulse: assert property (
        autoneg_restart_out |-> !soft_reset_out ##1 !autoneg_restart_out)
        else $error("restart pulse wrong");
    chk_ta_zero: assert property (
        $rose(mdio_oe_out) |-> !mdio_out) else $error("turnaround not zero");
    chk_oe_hold: assert property (
        $rose(mdio_oe_out) |=> mdio_oe_out [*8]) else $error("drive too short");
endmodule : phy_regs_props

// File: mdio_master.sv
// Management master model issuing full frames
`timescale 1ns/10ps
module mdio_master (
    input  wire logic mclk_in,
    input  wire logic md_in,
    output logic      mdc_out,
    output logic      md_out
);
    initial {mdc_out, md_out} = 2'b01;
    // Clock held 4 cycles per phase; read bits taken on the rise
    task automatic xfer(input logic [1:0] op, input logic [9:0] ad, input logic [15:0] wd,
                        output logic [15:0] rd);
        logic [63:0] f;
        f = {32'hffffffff, 2'b01, op, ad, 2'b10, wd};
        for (int i = 63; i >= 0; i--) begin
            md_out = (op == 2'b10 && i < 18) ? 1'b1 : f[i]; // Released: pull-up
            repeat (4) @(posedge mclk_in);
            #1 mdc_out = 1'b1;
            if (i < 16) rd[i] = md_in;
            repeat (4) @(posedge mclk_in);
            #1 mdc_out = 1'b0;
        end
    endtask : xfer
endmodule : mdio_master

// File: testbench.sv
// Self-checking bench for the basic PHY register block
`timescale 1ns/10ps
module testbench;
    logic mclk_in = 1'b0, rst_in = 1'b1, tx_en = 1'b0, col = 1'b0;
    logic mdc, md, mo, moe, spd, fdx, ltx, colo, srst, rsta;
    phy_regs_pkg::phy_cond_s  cond = 4'h0;
    phy_regs_pkg::an_result_s anr  = 2'b01;
    phy_regs_pkg::ctrl_s      ctrl;
    logic [15:0] rd;
    logic        strap = 1'b1;
    logic [15:0] n_srst = 16'h0000, n_rsta = 16'h0000;
    // Count one-cycle pulses so a task can judge them after the frame
    always @(posedge mclk_in) begin
        n_srst <= n_srst + {15'h0000, srst};
        n_rsta <= n_rsta + {15'h0000, rsta};
    end
    int bad_count = 0, n_checks = 0;
    wire mdio_w = moe ? mo : md;
    always #25 mclk_in = ~mclk_in;
    mdio_master mm (.mclk_in(mclk_in), .md_in(mdio_w), .mdc_out(mdc), .md_out(md));
    phy_basic_ctrl_status_regs dut (.mclk_in(mclk_in), .rst_in(rst_in), .mdc_in(mdc),
        .mdio_in(mdio_w), .mdio_out(mo), .mdio_oe_out(moe), .phy_addr_in(5'h03),
        .aneg_disable_in(strap), .cond_in(cond), .an_result_in(anr), .tx_en_in(tx_en),
        .line_col_in(col), .ctrl_out(ctrl), .speed_100_out(spd), .full_duplex_out(fdx),
        .line_tx_enable_out(ltx), .collision_out(colo), .soft_reset_out(srst),
        .autoneg_restart_out(rsta));
    task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask : chk
    task automatic rdr(input logic [9:0] ad, input logic [15:0] e, input string w);
        mm.xfer(2'b10, ad, 16'h0000, rd);
        chk(w, e, rd);
    endtask : rdr
    task automatic wrr(input logic [15:0] wd);
        mm.xfer(2'b01, 10'h060, wd, rd);
    endtask : wrr
    // Defaults, fixed bits and ignored frames
    task automatic t_reset;
        rdr(10'h060, 16'h2100, "ctrl reset");
        rdr(10'h061, 16'h7809, "status reset");
        rdr(10'h062, 16'hffff, "unmapped index");
        rdr(10'h081, 16'hffff, "other address");
    endtask : t_reset
    // Loopback, power down, collision test, forced and negotiated modes
    task automatic t_ctrl;
        wrr(16'h4880);
        tx_en = 1'b1;
        col = 1'b1;
        rdr(10'h060, 16'h4880, "ctrl readback");
        chk("collision", 16'h0001, {15'h0000, colo});
        chk("line tx", 16'h0000, {15'h0000, ltx});
        wrr(16'h0000);
        chk("forced mode", 16'h0000, {14'h0000, spd, fdx});
        chk("line collision", 16'h0001, {15'h0000, colo});
        chk("line tx on", 16'h0001, {15'h0000, ltx});
        wrr(16'h1200);
        chk("restart pulses", 16'h0001, n_rsta);
        rdr(10'h060, 16'h1000, "restart");
        chk("negotiated", 16'h0001, {14'h0000, spd, fdx});
        strap = 1'b0;
        wrr(16'h8000);
        chk("soft reset pulses", 16'h0001, n_srst);
        rdr(10'h060, 16'h3100, "soft reset");
        chk("ctrl out", 16'h001a, {10'h000, ctrl});
    endtask : t_ctrl
    // Latched status bits hold events until read
    task automatic t_latch;
        cond = 4'hf;
        repeat (4) @(posedge mclk_in);
        #1 cond = 4'ha; // Fault and jabber end before the read
        rdr(10'h061, 16'h783b, "latched");
        rdr(10'h061, 16'h782d, "current");
        cond = 4'h8;
        repeat (4) @(posedge mclk_in);
        #1 cond = 4'ha;
        rdr(10'h061, 16'h7829, "link loss");
    endtask : t_latch
    task automatic stop_test;
        if (bad_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test
    initial begin
        repeat (3) @(posedge mclk_in);
        #1 rst_in = 1'b0;
        repeat (4) @(posedge mclk_in);
        #1 t_reset;
        t_ctrl;
        t_latch;
        stop_test;
    end
endmodule : testbench
bind phy_basic_ctrl_status_regs phy_regs_props props (.*);
